// File: rtl/pfc_defs.svh
// Register offsets, field positions, reset values and counts of the PLL frequency control
`ifndef PFC_DEFS_SVH
`define PFC_DEFS_SVH

`define PFC_ADDR_W        4
`define PFC_SYNTH_CONTROL_REG_ADDR    4'h0
`define PFC_SYNTH_CONTROL_REG_RESET   16'h3f00
`define PFC_CTRL_RESET    8'h3f
`define PFC_CTRL_MSB      15
`define PFC_CTRL_LSB      8
`define PFC_TAP_BIT       15
`define PFC_HALF_BIT      14
`define PFC_LOCK_BIT      3
`define PFC_PREDIV_LAST   7'h7f
`define PFC_TAP_LAST_LO   6'h0f
`define PFC_TAP_LAST_HI   6'h3f
`define PFC_OUT_LAST_LO   2'h3
`define PFC_OUT_LAST_HI   2'h1
`define PFC_LOCK_COUNT    8'h10
`define PFC_RESET_MULT    12'h100

`endif

// File: rtl/pfc_pkg.sv
// Types shared by the PLL frequency control block
package pfc_pkg;

  // Frequency control byte, laid out as the upper register byte
  typedef struct packed {
    logic       tapSel;
    logic       halfOff;
    logic [5:0] modulus;
  } pfc_ctrl_s;

  // Register port request
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } pfc_req_s;

  // Whole block state
  typedef struct packed {
    logic [3:0]  sync1;
    logic [3:0]  sync2;
    logic [1:0]  prev;
    logic        pllMode;
    logic        rangeHigh;
    pfc_ctrl_s   ctrl;
    logic [6:0]  preDiv;
    logic [5:0]  fbPre;
    logic [5:0]  fbCnt;
    logic [1:0]  sysDiv;
    logic [1:0]  fbSeen;
    logic [7:0]  goodCnt;
    logic        locked;
    logic        chipRstn;
    logic        refTick;
    logic        fbTick;
    logic        sysTick;
    logic [11:0] sysMult;
    logic [15:0] rdata;
  } pfc_state_s;

endpackage : pfc_pkg

// File: rtl/pfc_pll_frequency_control.sv
// Digital frequency control of the PLL clock synthesizer
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/1ps
`include "pfc_defs.svh"

// Operation
// - Frequency set only by control register upper byte
// - Feedback modulus: 6-bit down counter, divide Y+1
// - Tap or modulus change forces a relock
// - Halving bit outside loop, no relock
// - Low range: system clock = ref*4(Y+1)*2^(2W+X)
// - High range: reference divided by 128 first
// - VCO is 2x or 4x system clock
// - Control register resets to 3F00
// - Low range reset gives 256 times reference
// - High range reset gives twice reference
// - Strap sampled in reset selects PLL or bypass
// - Lock bit readable; chip held until lock
module pfc_pll_frequency_control #(
  parameter logic [7:0] LOCK_COUNT = `PFC_LOCK_COUNT
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   resetn,
  // Pins from outside, asynchronous
  input  wire logic                   referenceInputPin,
  input  wire logic                   vcoClkPin,
  input  wire logic                   clockSourceStrap,
  input  wire logic                   refRangeHighStrap,
  // Register port
  input  wire logic [`PFC_ADDR_W-1:0] regAddr,
  input  wire logic [15:0]            regWdata,
  input  wire logic                   regWr,
  input  wire logic                   regRd,
  output logic      [15:0]            regRdata,
  // Loop and clock outputs
  output logic                        pllRefTick,
  output logic                        fbTick,
  output logic                        sysClkTick,
  output logic      [11:0]            sysMult,
  output logic                        lockStatusBit,
  output logic                        pllModeSel,
  output logic                        chipResetn
);

  pfc_pkg::pfc_state_s st_r;
  pfc_pkg::pfc_state_s st_nxt;
  pfc_pkg::pfc_req_s   req;

  logic refEdge;
  logic vcoEdge;
  logic pllRef;
  logic wrHit;
  logic loopChg;
  logic tapEnd;
  logic fbWrap;

  assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

  // Edges seen only after both synchroniser stages
  assign refEdge = st_r.sync2[0] & ~st_r.prev[0];
  assign vcoEdge = st_r.sync2[1] & ~st_r.prev[1];
  // High range reference reaches the loop once per 128 edges
  assign pllRef  = st_r.rangeHigh ? (refEdge && st_r.preDiv == `PFC_PREDIV_LAST)
                                  : refEdge;
  assign wrHit   = req.wr && req.addr == `PFC_SYNTH_CONTROL_REG_ADDR;
  // Only the in-loop fields force a relock; halving bit is outside.
  // Counters restart in bypass too, so a count never outruns a smaller modulus
  assign loopChg = wrHit
                   && (req.wdata[`PFC_TAP_BIT] != st_r.ctrl.tapSel
                   || req.wdata[13:8] != st_r.ctrl.modulus);
  assign tapEnd  = st_r.fbPre == (st_r.ctrl.tapSel ? `PFC_TAP_LAST_HI
                                                   : `PFC_TAP_LAST_LO);
  assign fbWrap  = vcoEdge && tapEnd && st_r.fbCnt == 6'h00;

  // Next state of the whole block
  always_comb begin
    st_nxt         = st_r;
    st_nxt.sync1   = {refRangeHighStrap, clockSourceStrap, vcoClkPin, referenceInputPin};
    st_nxt.sync2   = st_r.sync1;
    st_nxt.prev    = st_r.sync2[1:0];
    st_nxt.refTick = 1'b0;
    st_nxt.fbTick  = 1'b0;
    st_nxt.sysTick = 1'b0;
    st_nxt.rdata   = 16'h0000;
    if (!resetn) begin
      // Straps follow the pins through reset; last value holds at release
      st_nxt.pllMode   = st_r.sync2[2];
      st_nxt.rangeHigh = st_r.sync2[3];
      st_nxt.ctrl      = pfc_pkg::pfc_ctrl_s'(`PFC_CTRL_RESET);
      st_nxt.preDiv    = 7'h00;
      st_nxt.fbPre     = 6'h00;
      st_nxt.fbCnt     = 6'h00;
      st_nxt.sysDiv    = 2'h0;
      st_nxt.fbSeen    = 2'h0;
      st_nxt.goodCnt   = 8'h00;
      st_nxt.locked    = 1'b0;
      st_nxt.chipRstn  = 1'b0;
      st_nxt.sysMult   = `PFC_RESET_MULT;
    end else begin
      // Reference prescaler, only used in the high range
      if (refEdge && st_r.rangeHigh) begin
        st_nxt.preDiv = st_r.preDiv + 7'h01;
      end
      st_nxt.refTick = pllRef && st_r.pllMode;
      // Feedback: tap prescaler, then modulo down counter
      if (vcoEdge) begin
        st_nxt.fbPre = tapEnd ? 6'h00 : st_r.fbPre + 6'h01;
        if (tapEnd) begin
          st_nxt.fbCnt = (st_r.fbCnt == 6'h00) ? st_r.ctrl.modulus
                                               : st_r.fbCnt - 6'h01;
        end
      end
      st_nxt.fbTick = fbWrap && st_r.pllMode;
      // Output prescaler: VCO divided by 4, or by 2 with halving bit set
      if (!st_r.pllMode) begin
        st_nxt.sysTick = refEdge;
      end else if (vcoEdge) begin
        if (st_r.sysDiv >= (st_r.ctrl.halfOff ? `PFC_OUT_LAST_HI : `PFC_OUT_LAST_LO)) begin
          st_nxt.sysDiv  = 2'h0;
          st_nxt.sysTick = 1'b1;
        end else begin
          st_nxt.sysDiv = st_r.sysDiv + 2'h1;
        end
      end
      // Lock detect: exactly one feedback tick per loop reference tick
      if (pllRef) begin
        st_nxt.fbSeen = {1'b0, fbWrap};
        if (st_r.fbSeen == 2'h1) begin
          st_nxt.goodCnt = (st_r.goodCnt >= LOCK_COUNT) ? LOCK_COUNT
                                                        : st_r.goodCnt + 8'h01;
        end else begin
          st_nxt.goodCnt = 8'h00;
        end
      end else if (fbWrap && st_r.fbSeen != 2'h2) begin
        st_nxt.fbSeen = st_r.fbSeen + 2'h1;
      end
      // Register write takes the frequency byte only
      if (wrHit) begin
        st_nxt.ctrl = pfc_pkg::pfc_ctrl_s'(req.wdata[`PFC_CTRL_MSB:`PFC_CTRL_LSB]);
      end
      // A new divider restarts the loop; the old lock history is void
      if (loopChg) begin
        st_nxt.fbPre   = 6'h00;
        st_nxt.fbCnt   = req.wdata[13:8];
        st_nxt.fbSeen  = 2'h0;
        st_nxt.goodCnt = 8'h00;
      end
      st_nxt.locked   = !st_r.pllMode || (st_nxt.goodCnt >= LOCK_COUNT);
      // Chip leaves reset once the loop first locks, then stays out
      st_nxt.chipRstn = st_r.chipRstn || st_r.locked;
      st_nxt.sysMult  = ({6'h00, st_r.ctrl.modulus} + 12'h001)
                        << ({2'h0, st_r.ctrl.tapSel, 1'b0} + {3'h0, st_r.ctrl.halfOff}
                            + 4'h2);
      if (req.rd && req.addr == `PFC_SYNTH_CONTROL_REG_ADDR) begin
        st_nxt.rdata[`PFC_CTRL_MSB:`PFC_CTRL_LSB] = st_r.ctrl;
        st_nxt.rdata[`PFC_LOCK_BIT]               = st_r.locked;
      end
    end
  end

  // Single state register
  always_ff @(posedge clk) begin
    st_r <= st_nxt;
  end

  // Outputs straight from state flops
  assign regRdata      = st_r.rdata;
  assign pllRefTick    = st_r.refTick;
  assign fbTick        = st_r.fbTick;
  assign sysClkTick    = st_r.sysTick;
  assign sysMult       = st_r.sysMult;
  assign lockStatusBit = st_r.locked;
  assign pllModeSel    = st_r.pllMode;
  assign chipResetn    = st_r.chipRstn;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Write lands in the control byte one cycle later
  property p_ctrl_write;
    wrHit |=> st_r.ctrl == $past(req.wdata[15:8]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("control byte not taken from write data");

  // Down counter never holds more than the modulus
  property p_fb_range;
    st_r.fbCnt <= st_r.ctrl.modulus || $past(st_r.ctrl.modulus) != st_r.ctrl.modulus;
  endproperty
  a_fb_range: assert property (p_fb_range)
    else $error("feedback counter above modulus");

  // Loop change leaves lock low for a while
  property p_relock;
    loopChg && st_r.pllMode |=> !st_r.locked [*8];
  endproperty
  a_relock: assert property (p_relock)
    else $error("lock kept after divider change");

  // Halving bit alone does not drop lock
  property p_half_only;
    wrHit && st_r.pllMode && st_r.locked && !loopChg && !pllRef |=> st_r.locked;
  endproperty
  a_half_only: assert property (p_half_only)
    else $error("halving bit write dropped lock");

  // Multiplier follows the formula one cycle behind the byte
  property p_mult;
    ##1 st_r.sysMult == (({6'h00, $past(st_r.ctrl.modulus)} + 12'h001)
                         << ({2'h0, $past(st_r.ctrl.tapSel), 1'b0}
                             + {3'h0, $past(st_r.ctrl.halfOff)} + 4'h2));
  endproperty
  a_mult: assert property (p_mult)
    else $error("system multiplier wrong");

  // High range loop tick only at the end of 128 edges
  property p_prediv;
    st_r.refTick && st_r.rangeHigh |-> $past(st_r.preDiv) == `PFC_PREDIV_LAST;
  endproperty
  a_prediv: assert property (p_prediv)
    else $error("high range reference not divided by 128");

  // Reset leaves the documented control value and multiplier
  property p_reset_val;
    $rose(resetn) |-> st_r.ctrl == `PFC_CTRL_RESET && st_r.sysMult == `PFC_RESET_MULT;
  endproperty
  a_reset_val: assert property (p_reset_val)
    else $error("control reset value wrong");

  // Bypass always reads locked
  property p_bypass;
    ##1 !st_r.pllMode |-> st_r.locked;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypass mode not locked");

  // Chip reset releases only after lock
  property p_chip_rst;
    $rose(st_r.chipRstn) |-> $past(st_r.locked);
  endproperty
  a_chip_rst: assert property (p_chip_rst)
    else $error("chip released before lock");

  // Read data carries the control byte and lock bit of the read cycle
  property p_rd_map;
    $past(resetn) && $past(req.rd) && $past(req.addr) == `PFC_SYNTH_CONTROL_REG_ADDR
      |-> st_r.rdata == {$past(st_r.ctrl), 4'h0, $past(st_r.locked), 3'h0};
  endproperty
  a_rd_map: assert property (p_rd_map)
    else $error("read data does not match control byte and lock");

  // Read data idles at zero; unmapped reads give nothing
  property p_rd_idle;
    !($past(req.rd) && $past(req.addr) == `PFC_SYNTH_CONTROL_REG_ADDR) |-> st_r.rdata == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero outside a read");

  // Bypass keeps the loop ticks quiet; control bits have no effect on the ticks
  property p_bypass_quiet;
    !st_r.pllMode |-> !st_r.refTick && !st_r.fbTick;
  endproperty
  a_bypass_quiet: assert property (p_bypass_quiet)
    else $error("loop tick in bypass mode");

  // Strap choices stay fixed once reset is released
  property p_strap_hold;
    ##1 $stable(st_r.pllMode) && $stable(st_r.rangeHigh);
  endproperty
  a_strap_hold: assert property (p_strap_hold)
    else $error("strap choice changed outside reset");

  // System tick in PLL mode only follows a VCO edge
  property p_sys_src;
    st_r.sysTick && st_r.pllMode |-> $past(vcoEdge);
  endproperty
  a_sys_src: assert property (p_sys_src)
    else $error("system tick without VCO edge");

  // Feedback tick only when the down counter wraps from zero
  property p_fb_src;
    st_r.fbTick |-> $past(vcoEdge) && $past(st_r.fbCnt) == 6'h00;
  endproperty
  a_fb_src: assert property (p_fb_src)
    else $error("feedback tick without counter wrap");

  // Low range loop reference is the raw reference edge
  property p_ref_src;
    st_r.refTick && !st_r.rangeHigh |-> $past(refEdge);
  endproperty
  a_ref_src: assert property (p_ref_src)
    else $error("low range loop tick without reference edge");

  // Chip stays in reset while the loop is unlocked
  property p_chip_hold;
    !st_r.locked && !st_r.chipRstn |=> !st_r.chipRstn;
  endproperty
  a_chip_hold: assert property (p_chip_hold)
    else $error("chip released while unlocked");

  // Once out of reset the chip stays out; a later relock does not stop it
  property p_chip_stay;
    st_r.chipRstn |=> st_r.chipRstn;
  endproperty
  a_chip_stay: assert property (p_chip_stay)
    else $error("chip reset reasserted without reset");

endmodule : pfc_pll_frequency_control

// File: sim/pfc_clock_source.sv
// Reference crystal and VCO image model for the frequency control bench
`timescale 1ns/1ps
module pfc_clock_source (
  // Clock
  input  wire logic        clk,
  // Half periods in clk cycles
  input  wire logic [15:0] refHalf,
  input  wire logic [15:0] vcoHalf,
  // Oscillator pins
  output logic             referenceInputPin,
  output logic             vcoClkPin
);
  logic [15:0] refCnt = 16'h0;
  logic [15:0] vcoCnt = 16'h0;
  // Start low; both run free, as a crystal and a VCO never stop
  initial begin
    referenceInputPin = 1'b0;
    vcoClkPin = 1'b0;
  end
  // Wrap on >= so a shorter half period applies at once
  always @(posedge clk) begin
    refCnt <= (refCnt + 16'h1 >= refHalf) ? 16'h0 : refCnt + 16'h1;
    vcoCnt <= (vcoCnt + 16'h1 >= vcoHalf) ? 16'h0 : vcoCnt + 16'h1;
    if (refCnt + 16'h1 >= refHalf) referenceInputPin <= !referenceInputPin;
    if (vcoCnt + 16'h1 >= vcoHalf) vcoClkPin <= !vcoClkPin;
  end
endmodule : pfc_clock_source

// File: sim/pfc_pll_frequency_control_test.sv
// Self-checking bench of the PLL frequency control block
`timescale 1ns/1ps
module pfc_pll_frequency_control_test;
  logic        clk, resetn, clockSourceStrap, rangeStrap, referenceInputPin, vcoClkPin;
  logic        regWr, regRd, pllRefTick, fbTick, sysClkTick;
  logic        lockStatusBit, pllModeSel, chipResetn;
  logic [3:0]  regAddr;
  logic [15:0] regWdata, regRdata, refHalf, vcoHalf, lfsr, d, v, n;
  logic [11:0] sysMult;
  int          miscompares = 0;
  int          nChecks = 0;

  // Short lock count keeps the run brief
  pfc_pll_frequency_control #(.LOCK_COUNT(8'h04)) pfc_pll_frequency_control_inst (
    .clk(clk), .resetn(resetn), .referenceInputPin(referenceInputPin),
    .vcoClkPin(vcoClkPin), .clockSourceStrap(clockSourceStrap),
    .refRangeHighStrap(rangeStrap), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .pllRefTick(pllRefTick),
    .fbTick(fbTick), .sysClkTick(sysClkTick), .sysMult(sysMult),
    .lockStatusBit(lockStatusBit), .pllModeSel(pllModeSel), .chipResetn(chipResetn));
  pfc_clock_source pfc_clock_source_inst (.clk(clk), .refHalf(refHalf), .vcoHalf(vcoHalf),
    .referenceInputPin(referenceInputPin), .vcoClkPin(vcoClkPin));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = !clk;
  end

  function automatic logic [15:0] next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : next

  // Expected multiplier 4(Y+1)*2^(2W+X)
  function automatic logic [11:0] mult(input logic [7:0] c);
    return (12'h004 * ({6'h00, c[5:0]} + 12'h001)) << {c[7], c[6]};
  endfunction : mult

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    nChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // One bus cycle; read data taken in the only cycle it stands
  task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] dat,
                     output logic [15:0] r);
    regAddr <= a;
    regWdata <= dat;
    regWr <= w;
    regRd <= !w;
    @(posedge clk);
    regWr <= 1'b0;
    regRd <= 1'b0;
    #1 r = regRdata;
    @(posedge clk);
  endtask : bus

  task automatic doReset(input logic mode, input logic range);
    resetn <= 1'b0;
    clockSourceStrap <= mode;
    rangeStrap <= range;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
  endtask : doReset

  // Bounded wait; a missed lock shows in the caller's check
  task automatic waitLock();
    n = 16'h0;
    do begin @(posedge clk); #1 n++; end while (lockStatusBit !== 1'b1 && n < 16'hc000);
    @(posedge clk);
  endtask : waitLock

  // Cycles between two pulses of sysClkTick (sel 0), pllRefTick (1) or fbTick (2)
  task automatic gap(input logic [1:0] sel, output logic [15:0] g);
    repeat (2) begin
      g = 16'h0;
      do begin @(posedge clk); #1 g++; end
        while ((sel[1] ? fbTick : sel[0] ? pllRefTick : sysClkTick) !== 1'b1
               && g < 16'h1000);
    end
    @(posedge clk);
  endtask : gap

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  // Hang guard, well above the longest lock wait
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    wrap_up();
  end

  // Main sequence
  initial begin
    {resetn, regWr, regRd, regAddr, regWdata} = '0;
    {clockSourceStrap, rangeStrap, lfsr, vcoHalf, refHalf} = {2'b10, 16'h0045, 16'h2, 16'h800};
    @(posedge clk);
    doReset(1'b1, 1'b0);
    bus(1'b0, 4'h0, 16'h0, v);
    check(v, 16'h3f00);
    check({4'h0, sysMult}, 16'h0100);
    check({15'h0, chipResetn}, 16'h0);
    waitLock();
    #1 check({15'h0, chipResetn}, 16'h1);
    @(posedge clk);
    bus(1'b0, 4'h0, 16'h0, v);
    check(v, 16'h3f08);
    gap(2'h0, v);
    check(v, 16'd16);
    bus(1'b1, 4'h0, 16'h7f00, v);
    bus(1'b0, 4'h0, 16'h0, v);
    check(v, 16'h7f08);
    gap(2'h0, v);
    check(v, 16'd8);
    $display("test reset and lock done");
    // Raise frequency with halving clear, relock, then halve; stays in range
    bus(1'b1, 4'h0, 16'h0355, v);
    refHalf <= 16'd128;
    bus(1'b0, 4'h0, 16'h0, v);
    check(v, 16'h0300);
    waitLock();
    // Tap 16, modulus 4, VCO period 4 clocks: feedback every 256 clocks
    gap(2'h2, v);
    check(v, 16'h0100);
    bus(1'b1, 4'h0, 16'h4300, v);
    bus(1'b0, 4'h0, 16'h0, v);
    check(v, 16'h4308);
    check({4'h0, sysMult}, {4'h0, mult(8'h43)});
    bus(1'b1, 4'h0, 16'h8000, v);
    bus(1'b0, 4'h0, 16'h0, v);
    check(v, 16'h8000);
    waitLock();
    check({15'h0, lockStatusBit}, 16'h1);
    // Tap 64, modulus 1: feedback again every 256 clocks
    gap(2'h2, v);
    check(v, 16'h0100);
    $display("test relock done");
    // Corner settings first, then random ones
    for (int i = 0; i < 12; i++) begin
      lfsr = next(lfsr);
      d = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : lfsr;
      bus(1'b1, 4'h0, d, v);
      bus(1'b1, 4'h9, ~d, v);
      bus(1'b0, 4'h0, 16'h0, v);
      check(v & 16'hfff7, d & 16'hff00);
      check({4'h0, sysMult}, {4'h0, mult(d[15:8])});
      bus(1'b0, 4'h9, 16'h0, v);
      check(v, 16'h0);
    end
    $display("test settings done");
    refHalf <= 16'd2;
    doReset(1'b1, 1'b1);
    gap(2'h1, v);
    check(v, 16'd512);
    check({4'h0, sysMult}, 16'h0100);
    $display("test high range done");
    refHalf <= 16'd8;
    doReset(1'b0, 1'b0);
    #1 check({14'h0, pllModeSel, lockStatusBit}, 16'h1);
    @(posedge clk);
    bus(1'b1, 4'h0, 16'h0000, v);
    gap(2'h0, v);
    check(v, 16'd16);
    $display("test bypass done");
    wrap_up();
  end
endmodule : pfc_pll_frequency_control_test
